// ---- hdl/xbus_decode_pkg.sv ----
// constants, types and address map shared by the peripheral enable decoder
package xbus_decode_pkg;

  localparam int ADDR_W = 24;
  localparam int REG_AW = 2;
  localparam int DATA_W = 16;

  // register offsets on the plain register port
  localparam logic [1:0] OFF_PERIPH_ENABLE = 2'h0;
  localparam logic [1:0] OFF_SYS_CONFIG = 2'h1;
  localparam logic [1:0] OFF_STATUS = 2'h2;

  // bit positions inside peripheral_enable_select
  localparam int BIT_FIRST_CAN = 0;
  localparam int BIT_SECOND_CAN = 1;
  localparam int BIT_SMALL_RAM = 2;
  localparam int BIT_LARGE_RAM = 3;
  localparam int BIT_RTC = 4;
  localparam int BIT_EXT_FLASH = 5;
  localparam int BIT_EXT_PWM = 6;
  localparam int BIT_ASYNC_SERIAL = 7;
  localparam int BIT_SYNC_SERIAL = 8;
  localparam int BIT_I2C = 9;
  localparam int BIT_MISC = 10;
  localparam int ENABLE_W = 11;

  // system_configuration and status field positions
  localparam int BIT_GLOBAL_ENABLE = 0;
  localparam int BIT_STAT_EXT_ACCESS = 0;
  localparam int BIT_STAT_EMULATION = 1;
  localparam int BIT_STAT_EFFECTIVE = 4;

  localparam logic [15:0] PERIPH_ENABLE_RESET = 16'h0005;
  localparam logic [15:0] PERIPH_ENABLE_MASK = 16'h07ff;
  // enables of the non-memory extension-bus peripherals
  localparam logic [15:0] PERIPH_ONLY_MASK = 16'h07d3;

  // cycles after reset release before the external-access level is caught
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

  localparam logic [23:0] SEG8_LO = 24'h080000;
  localparam logic [23:0] SEG8_HI = 24'h08ffff;
  localparam logic [23:0] FLASH_LO = 24'h090000;
  localparam logic [23:0] FLASH_HI = 24'h0effff;
  localparam logic [23:0] LARGE_RAM_LO = 24'h0f0000;
  localparam logic [23:0] LARGE_RAM_HI = 24'h0fffff;
  localparam logic [23:0] WINDOW_LO = 24'h00e800;
  localparam logic [23:0] WINDOW_HI = 24'h00efff;
  localparam logic [23:0] SYNC_SERIAL_LO = 24'h00e800;
  localparam logic [23:0] SYNC_SERIAL_HI = 24'h00e8ff;
  localparam logic [23:0] ASYNC_SERIAL_LO = 24'h00e900;
  localparam logic [23:0] ASYNC_SERIAL_HI = 24'h00e9ff;
  localparam logic [23:0] I2C_LO = 24'h00ea00;
  localparam logic [23:0] I2C_HI = 24'h00eaff;
  localparam logic [23:0] MISC_LO = 24'h00eb00;
  localparam logic [23:0] MISC_HI = 24'h00ebff;
  localparam logic [23:0] PWM_LO = 24'h00ec00;
  localparam logic [23:0] PWM_HI = 24'h00ecff;
  localparam logic [23:0] RTC_LO = 24'h00ed00;
  localparam logic [23:0] RTC_HI = 24'h00edff;
  localparam logic [23:0] SECOND_CAN_LO = 24'h00ee00;
  localparam logic [23:0] SECOND_CAN_HI = 24'h00eeff;
  localparam logic [23:0] FIRST_CAN_LO = 24'h00ef00;
  localparam logic [23:0] FIRST_CAN_HI = 24'h00efff;

  typedef enum logic [3:0] {
    rg_none = 4'h0,
    rg_first_can = 4'h1,
    rg_second_can = 4'h2,
    rg_small_ram = 4'h3,
    rg_large_ram = 4'h4,
    rg_rtc = 4'h5,
    rg_ext_pwm = 4'h6,
    rg_ext_flash = 4'h7,
    rg_async_serial = 4'h8,
    rg_sync_serial = 4'h9,
    rg_i2c = 4'ha,
    rg_misc = 4'hb,
    rg_seg8 = 4'hc
  } region_t;

  typedef enum logic [2:0] {
    tgt_pass = 3'h0,
    tgt_internal = 3'h1,
    tgt_external = 3'h2,
    tgt_iflash_b1f1 = 3'h3,
    tgt_reserved = 3'h4,
    tgt_xbus_unclaimed = 3'h5
  } target_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [23:0] addr;
  } access_t;

  typedef struct packed {
    logic valid;
    logic write;
    target_t target;
    region_t region;
  } route_t;

  function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo, input logic [23:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

endpackage : xbus_decode_pkg

// ---- hdl/level_sync.sv ----
// two-flop synchroniser for slow levels coming from pins
`timescale 1ns/1ns
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end
    else
    begin
      stage1_ff <= async_in;
      stage2_ff <= stage1_ff;
    end
  end

  assign sync_out = stage2_ff;
endmodule : level_sync

// ---- hdl/region_classify.sv ----
// classifies a cpu data address into the regions this decoder steers
`timescale 1ns/1ns
module region_classify #(
  parameter logic [23:0] SMALL_RAM_LO = 24'h00e000,
  parameter logic [23:0] SMALL_RAM_HI = 24'h00e7ff
) (
  input wire logic [23:0] addr,
  output xbus_decode_pkg::region_t region
);
  import xbus_decode_pkg::*;

  always_comb
  begin
    region = rg_none;
    if (in_range(addr, SEG8_LO, SEG8_HI))
      region = rg_seg8;
    else if (in_range(addr, FLASH_LO, FLASH_HI))
      region = rg_ext_flash;
    else if (in_range(addr, LARGE_RAM_LO, LARGE_RAM_HI))
      region = rg_large_ram;
    else if (in_range(addr, SMALL_RAM_LO, SMALL_RAM_HI))
      region = rg_small_ram;
    else if (in_range(addr, SYNC_SERIAL_LO, SYNC_SERIAL_HI))
      region = rg_sync_serial;
    else if (in_range(addr, ASYNC_SERIAL_LO, ASYNC_SERIAL_HI))
      region = rg_async_serial;
    else if (in_range(addr, I2C_LO, I2C_HI))
      region = rg_i2c;
    else if (in_range(addr, MISC_LO, MISC_HI))
      region = rg_misc;
    else if (in_range(addr, PWM_LO, PWM_HI))
      region = rg_ext_pwm;
    else if (in_range(addr, RTC_LO, RTC_HI))
      region = rg_rtc;
    else if (in_range(addr, SECOND_CAN_LO, SECOND_CAN_HI))
      region = rg_second_can;
    else if (in_range(addr, FIRST_CAN_LO, FIRST_CAN_HI))
      region = rg_first_can;
  end
endmodule : region_classify

// ---- hdl/xbus_peripheral_enable_decoder.sv ----
// extension-bus peripheral enable register and cpu data access router
// Operation
// - With the large RAM disabled its accesses are blocked, and 0F'0000h-0F'FFFFh goes outside only if flash is off too.
// - With the RTC disabled, 00'ED00h-00'EDFFh goes outside only if every other peripheral enable is clear.
// - With the extension PWM disabled, 00'EC00h-00'ECFFh goes outside only if every other peripheral enable is clear.
// - With extended flash disabled, 09'0000h-0E'FFFFh goes outside only if the large RAM is off too.
// - With the async serial disabled, 00'E900h-00'E9FFh goes outside only if every other peripheral enable is clear.
// - With the sync serial disabled, 00'E800h-00'E8FFh goes outside only if every other peripheral enable is clear.
// - With the I2C disabled, 00'EA00h-00'EAFFh goes outside only if every other peripheral enable is clear.
// - With misc features disabled, 00'EB00h-00'EBFFh goes outside only if every other peripheral enable is clear.
// - With both CANs and all other peripherals disabled, the whole 00'E800h-00'EFFFh window goes outside.
// - Pins of a disabled peripheral are released for general-purpose use.
// - Reset enables the first CAN and small RAM and disables everything else.
// - Once the global enable flag is set, writes to the enable register are ignored.
// - In emulation all peripheral enables read as set and the bondout logic picks internal or external for the 00'E800h-00'EFFFh window.
// - Segment 8 maps to flash block B1F1 if the external-access pin was high at reset, else outside while the flag is clear.
// - Segment 8 with the pin low and the flag set goes outside if large RAM and flash are off, else is reserved.
`timescale 1ns/1ns
module xbus_peripheral_enable_decoder #(
  parameter logic [23:0] SMALL_RAM_LO = 24'h00e000,
  parameter logic [23:0] SMALL_RAM_HI = 24'h00e7ff
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [xbus_decode_pkg::REG_AW-1:0] reg_addr,
  input wire logic [xbus_decode_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [xbus_decode_pkg::DATA_W-1:0] reg_rdata,
  input wire xbus_decode_pkg::access_t cpu_access,
  output xbus_decode_pkg::route_t access_route,
  input wire logic external_access_pin,
  input wire logic emulation_mode_pin,
  input wire logic bondout_route_external,
  output logic [xbus_decode_pkg::ENABLE_W-1:0] module_enable,
  output logic [xbus_decode_pkg::ENABLE_W-1:0] pin_release
);
  import xbus_decode_pkg::*;

  logic [15:0] peripheral_enable_select_ff;
  logic global_peripheral_enable_flag_ff;
  logic ext_access_strap_ff;
  logic [1:0] strap_count_ff;
  logic [DATA_W-1:0] rdata_ff;
  route_t route_ff;
  logic [ENABLE_W-1:0] enable_out_ff;
  logic [ENABLE_W-1:0] release_ff;

  logic [1:0] pins_sync;
  logic ext_access_sync;
  logic emulation_mode;

  logic [15:0] effective_enable;
  logic [15:0] nxt_peripheral_enable_select;
  logic [DATA_W-1:0] nxt_rdata;
  route_t nxt_route;
  region_t access_region;

  level_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .clk(clk),
    .reset(reset),
    .async_in({emulation_mode_pin, external_access_pin}),
    .sync_out(pins_sync)
  );

  assign ext_access_sync = pins_sync[0];
  assign emulation_mode = pins_sync[1];

  region_classify #(
    .SMALL_RAM_LO(SMALL_RAM_LO),
    .SMALL_RAM_HI(SMALL_RAM_HI)
  ) u_region (
    .addr(cpu_access.addr),
    .region(access_region)
  );

  // true when no enable other than the one at position self is set among the non-memory peripherals
  function automatic logic others_clear(input logic [15:0] en, input int self);
    logic [15:0] others;
    others = en & PERIPH_ONLY_MASK;
    others[self] = 1'b0;
    others_clear = (others == 16'h0000);
  endfunction : others_clear

  // the enable register itself; reserved bits never store
  always_comb
  begin
    nxt_peripheral_enable_select = peripheral_enable_select_ff;
    if (reg_write && reg_addr == OFF_PERIPH_ENABLE && !global_peripheral_enable_flag_ff)
      nxt_peripheral_enable_select = reg_wdata & PERIPH_ENABLE_MASK;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      peripheral_enable_select_ff <= PERIPH_ENABLE_RESET;
    else
      peripheral_enable_select_ff <= nxt_peripheral_enable_select;
  end

  // the global flag only sets; it stays until the next reset so the lock cannot be undone
  always_ff @(posedge clk)
  begin
    if (reset)
      global_peripheral_enable_flag_ff <= 1'b0;
    else if (reg_write && reg_addr == OFF_SYS_CONFIG && reg_wdata[BIT_GLOBAL_ENABLE])
      global_peripheral_enable_flag_ff <= 1'b1;
  end

  // catch the external-access level once the synchroniser has filled after reset release
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      strap_count_ff <= 2'h0;
      ext_access_strap_ff <= 1'b0;
    end
    else if (strap_count_ff != STRAP_SETTLE_CYCLES)
    begin
      strap_count_ff <= strap_count_ff + 2'h1;
      if (strap_count_ff == STRAP_SETTLE_CYCLES - 2'h1)
        ext_access_strap_ff <= ext_access_sync;
    end
  end

  // modules are live only once globally enabled; emulation forces every enable on
  always_comb
  begin
    if (emulation_mode)
      effective_enable = PERIPH_ENABLE_MASK;
    else if (global_peripheral_enable_flag_ff)
      effective_enable = peripheral_enable_select_ff;
    else
      effective_enable = 16'h0000;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      enable_out_ff <= '0;
      release_ff <= '1;
    end
    else
    begin
      enable_out_ff <= effective_enable[ENABLE_W-1:0];
      release_ff <= ~effective_enable[ENABLE_W-1:0];
    end
  end

  assign module_enable = enable_out_ff;
  assign pin_release = release_ff;

  // routing: one target per access, decided from the enables of this very cycle
  always_comb
  begin
    nxt_route.valid = cpu_access.valid;
    nxt_route.write = cpu_access.write;
    nxt_route.region = access_region;
    nxt_route.target = tgt_pass;
    case (access_region)
      rg_seg8:
      begin
        if (ext_access_strap_ff)
          nxt_route.target = tgt_iflash_b1f1;
        else if (!global_peripheral_enable_flag_ff)
          nxt_route.target = tgt_external;
        else if (!peripheral_enable_select_ff[BIT_LARGE_RAM] && !peripheral_enable_select_ff[BIT_EXT_FLASH])
          nxt_route.target = tgt_external;
        else
          nxt_route.target = tgt_reserved;
      end
      rg_ext_flash:
      begin
        if (effective_enable[BIT_EXT_FLASH])
          nxt_route.target = tgt_internal;
        else if (!effective_enable[BIT_LARGE_RAM])
          nxt_route.target = tgt_external;
        else
          nxt_route.target = tgt_xbus_unclaimed;
      end
      rg_large_ram:
      begin
        if (effective_enable[BIT_LARGE_RAM])
          nxt_route.target = tgt_internal;
        else if (!effective_enable[BIT_EXT_FLASH])
          nxt_route.target = tgt_external;
        else
          nxt_route.target = tgt_xbus_unclaimed;
      end
      rg_small_ram:
      begin
        if (effective_enable[BIT_SMALL_RAM])
          nxt_route.target = tgt_internal;
        else
          nxt_route.target = tgt_external;
      end
      rg_rtc:
        nxt_route.target = window_target(effective_enable, BIT_RTC);
      rg_ext_pwm:
        nxt_route.target = window_target(effective_enable, BIT_EXT_PWM);
      rg_async_serial:
        nxt_route.target = window_target(effective_enable, BIT_ASYNC_SERIAL);
      rg_sync_serial:
        nxt_route.target = window_target(effective_enable, BIT_SYNC_SERIAL);
      rg_i2c:
        nxt_route.target = window_target(effective_enable, BIT_I2C);
      rg_misc:
        nxt_route.target = window_target(effective_enable, BIT_MISC);
      rg_second_can:
        nxt_route.target = window_target(effective_enable, BIT_SECOND_CAN);
      rg_first_can:
        nxt_route.target = window_target(effective_enable, BIT_FIRST_CAN);
      default:
        nxt_route.target = tgt_pass;
    endcase
    // in emulation the bondout logic has the last word for the peripheral window
    if (emulation_mode && in_range(cpu_access.addr, WINDOW_LO, WINDOW_HI))
    begin
      if (bondout_route_external)
        nxt_route.target = tgt_external;
      else
        nxt_route.target = tgt_internal;
    end
  end

  // a disabled module inside the shared window reaches outside only when the whole window is free
  function automatic target_t window_target(input logic [15:0] en, input int self);
    if (en[self])
      window_target = tgt_internal;
    else if (others_clear(en, self))
      window_target = tgt_external;
    else
      window_target = tgt_xbus_unclaimed;
  endfunction : window_target

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      route_ff.valid <= 1'b0;
      route_ff.write <= 1'b0;
      route_ff.target <= tgt_pass;
      route_ff.region <= rg_none;
    end
    else
      route_ff <= nxt_route;
  end

  assign access_route = route_ff;

  // register read data, valid only in the cycle after the read strobe
  always_comb
  begin
    nxt_rdata = '0;
    if (reg_read)
    begin
      case (reg_addr)
        OFF_PERIPH_ENABLE:
          nxt_rdata = peripheral_enable_select_ff;
        OFF_SYS_CONFIG:
          nxt_rdata[BIT_GLOBAL_ENABLE] = global_peripheral_enable_flag_ff;
        OFF_STATUS:
        begin
          nxt_rdata[BIT_STAT_EXT_ACCESS] = ext_access_strap_ff;
          nxt_rdata[BIT_STAT_EMULATION] = emulation_mode;
          nxt_rdata[BIT_STAT_EFFECTIVE +: ENABLE_W] = effective_enable[ENABLE_W-1:0];
        end
        default:
          nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      rdata_ff <= '0;
    else
      rdata_ff <= nxt_rdata;
  end

  assign reg_rdata = rdata_ff;
endmodule : xbus_peripheral_enable_decoder

// ---- sim/xbus_decoder_properties.sv ----
// port assertions for the peripheral enable decoder
`timescale 1ns/1ns
module xbus_decoder_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic [xbus_decode_pkg::REG_AW-1:0] reg_addr,
  input wire logic [xbus_decode_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [xbus_decode_pkg::DATA_W-1:0] reg_rdata,
  input wire xbus_decode_pkg::access_t cpu_access,
  input wire xbus_decode_pkg::route_t access_route,
  input wire logic external_access_pin,
  input wire logic emulation_mode_pin,
  input wire logic bondout_route_external,
  input wire logic [xbus_decode_pkg::ENABLE_W-1:0] module_enable,
  input wire logic [xbus_decode_pkg::ENABLE_W-1:0] pin_release
);
  import xbus_decode_pkg::*;
  logic v;
  logic [23:0] a;
  logic pwm_blk;
  logic mem_off;
  logic per_off;
  assign v = cpu_access.valid;
  assign a = cpu_access.addr;
  // enables must hold over both cycles, since the route is registered
  assign pwm_blk = !module_enable[BIT_EXT_PWM] && (|(module_enable & 11'h793));
  assign mem_off = !module_enable[BIT_EXT_FLASH] && !module_enable[BIT_LARGE_RAM];
  assign per_off = (module_enable & 11'h7d3) == 11'h000;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_release;
    pin_release == ~module_enable;
  endproperty
  a_release: assert property (p_release) else $error("pin release mismatch");
  property p_reset;
    $past(reset) |-> module_enable == 11'h000 && pin_release == 11'h7ff;
  endproperty
  a_reset: assert property (p_reset) else $error("enables after reset");
  property p_valid;
    !$past(reset) |-> access_route.valid == $past(cpu_access.valid);
  endproperty
  a_valid: assert property (p_valid) else $error("route valid lost");
  property p_lram;
    v && a[23:16] == 8'h0f && module_enable[BIT_LARGE_RAM] ##1 module_enable[BIT_LARGE_RAM]
      |-> access_route.target == tgt_internal;
  endproperty
  a_lram: assert property (p_lram) else $error("large ram not internal");
  property p_flash;
    v && a[23:16] inside {[8'h09:8'h0e]} && mem_off ##1 mem_off |-> access_route.target == tgt_external;
  endproperty
  a_flash: assert property (p_flash) else $error("flash not external");
  property p_pwm;
    v && a[23:8] == 16'h00ec && pwm_blk ##1 pwm_blk |-> access_route.target == tgt_xbus_unclaimed;
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm window went outside");
  property p_win;
    v && a[23:11] == 13'h001d && per_off ##1 per_off |-> access_route.target == tgt_external;
  endproperty
  a_win: assert property (p_win) else $error("window not external");
  property p_seg8;
    v && a[23:16] == 8'h08 |=> access_route.region == rg_seg8
      && access_route.target inside {tgt_external, tgt_iflash_b1f1, tgt_reserved};
  endproperty
  a_seg8: assert property (p_seg8) else $error("segment 8 route");
  property p_rtc;
    v && a[23:8] == 16'h00ed |=> access_route.region == rg_rtc && access_route.target != tgt_pass;
  endproperty
  a_rtc: assert property (p_rtc) else $error("rtc window route");
  property p_pass;
    v && a < 24'h00e000 |=> access_route.target == tgt_pass && access_route.region == rg_none;
  endproperty
  a_pass: assert property (p_pass) else $error("low address decoded");
endmodule : xbus_decoder_properties

bind xbus_peripheral_enable_decoder xbus_decoder_properties chk (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .cpu_access(cpu_access), .access_route(access_route),
  .external_access_pin(external_access_pin), .emulation_mode_pin(emulation_mode_pin),
  .bondout_route_external(bondout_route_external), .module_enable(module_enable),
  .pin_release(pin_release)
);

// ---- sim/cpu_bus_model.sv ----
// cpu data side: presents one access and picks up its route
`timescale 1ns/1ns
module cpu_bus_model (
  input wire logic clk,
  output xbus_decode_pkg::access_t cpu_access,
  input wire xbus_decode_pkg::route_t access_route
);
  import xbus_decode_pkg::*;
  initial cpu_access = '0;
  // idle bus shows the inverted address so a stale value cannot decode by luck
  task automatic issue(input logic [23:0] a, output route_t r);
    @(posedge clk);
    cpu_access <= '{valid: 1'b1, write: 1'b0, addr: a};
    @(posedge clk);
    cpu_access <= '{valid: 1'b0, write: 1'b1, addr: ~a};
    #1;
    r = access_route;
  endtask : issue
endmodule : cpu_bus_model

// ---- sim/testbench.sv ----
// self-checking bench for the peripheral enable decoder
`timescale 1ns/1ns
module testbench;
  import xbus_decode_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [15:0] reg_rdata;
  access_t cpu_access;
  route_t access_route;
  logic external_access_pin = 1'b0;
  logic emulation_mode_pin = 1'b0;
  logic bondout_route_external = 1'b0;
  logic [10:0] module_enable;
  logic [10:0] pin_release;
  int mismatches = 0;
  int total_checks = 0;
  route_t r;
  logic [23:0] win_a [8] = '{24'h00ef00, 24'h00eeff, 24'h00ed00, 24'h00ecff,
                             24'h00eb00, 24'h00eaff, 24'h00e900, 24'h00e8ff};
  region_t win_g [8] = '{rg_first_can, rg_second_can, rg_rtc, rg_ext_pwm,
                         rg_misc, rg_i2c, rg_async_serial, rg_sync_serial};

  always #5 clk = ~clk;

  xbus_peripheral_enable_decoder DUT (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .cpu_access(cpu_access), .access_route(access_route),
    .external_access_pin(external_access_pin), .emulation_mode_pin(emulation_mode_pin),
    .bondout_route_external(bondout_route_external), .module_enable(module_enable),
    .pin_release(pin_release)
  );

  cpu_bus_model cpu (
    .clk(clk),
    .cpu_access(cpu_access),
    .access_route(access_route)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask : rd

  // the model always issues a valid read, so valid and write come back as 1 and 0
  task automatic acc(input logic [23:0] a, input target_t t, input region_t g);
    cpu.issue(a, r);
    check(16'({r.valid, r.write, r.target, r.region}), 16'({1'b1, 1'b0, t, g}));
  endtask : acc

  // the strap is caught a few edges after release, so wait past it
  task automatic do_reset(input logic pin);
    @(posedge clk);
    reset <= 1'b1;
    external_access_pin <= pin;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : do_reset

  initial
  begin
    #100000;
    mismatches++;
    summarize;
  end

  initial
  begin
    do_reset(1'b0);
    rd(OFF_PERIPH_ENABLE, 16'h0005);
    rd(2'h3, 16'h0000);
    rd(OFF_STATUS, 16'h0000);
    check(16'(pin_release), 16'h07ff);
    for (int i = 0; i < 8; i++)
      acc(win_a[i], tgt_external, win_g[i]);
    acc(24'h080000, tgt_external, rg_seg8);
    acc(24'h0effff, tgt_external, rg_ext_flash);
    acc(24'h0f0000, tgt_external, rg_large_ram);
    wr(OFF_PERIPH_ENABLE, 16'h0048);
    rd(OFF_PERIPH_ENABLE, 16'h0048);
    rd(OFF_SYS_CONFIG, 16'h0000);
    wr(OFF_SYS_CONFIG, 16'h0001);
    rd(OFF_SYS_CONFIG, 16'h0001);
    wr(OFF_PERIPH_ENABLE, 16'h07ff);
    rd(OFF_PERIPH_ENABLE, 16'h0048);
    rd(OFF_STATUS, 16'h0480);
    check(16'(pin_release), 16'h07b7);
    acc(24'h00ec10, tgt_internal, rg_ext_pwm);
    acc(24'h00ed10, tgt_xbus_unclaimed, rg_rtc);
    acc(24'h0fffff, tgt_internal, rg_large_ram);
    acc(24'h090000, tgt_xbus_unclaimed, rg_ext_flash);
    acc(24'h08ffff, tgt_reserved, rg_seg8);
    acc(24'h001000, tgt_pass, rg_none);
    do_reset(1'b0);
    rd(OFF_PERIPH_ENABLE, 16'h0005);
    rd(OFF_SYS_CONFIG, 16'h0000);
    wr(OFF_SYS_CONFIG, 16'h0001);
    acc(24'h088000, tgt_external, rg_seg8);
    acc(24'h00e810, tgt_xbus_unclaimed, rg_sync_serial);
    acc(24'h00ec00, tgt_xbus_unclaimed, rg_ext_pwm);
    acc(24'h00e000, tgt_internal, rg_small_ram);
    @(posedge clk);
    emulation_mode_pin <= 1'b1;
    bondout_route_external <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check(16'(module_enable), 16'h07ff);
    check(16'(pin_release), 16'h0000);
    acc(24'h00e910, tgt_external, rg_async_serial);
    @(posedge clk);
    bondout_route_external <= 1'b0;
    acc(24'h00e910, tgt_internal, rg_async_serial);
    @(posedge clk);
    emulation_mode_pin <= 1'b0;
    do_reset(1'b1);
    rd(OFF_STATUS, 16'h0001);
    acc(24'h080000, tgt_iflash_b1f1, rg_seg8);
    summarize;
  end
endmodule : testbench
